//--- sbc_defs.svh
// Register offsets, field positions, reset values and timing counts of the baseband control
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH
`define SBC_A_MODE      7'h00
`define SBC_A_TXPOW     7'h01
`define SBC_A_TXCFG     7'h02
`define SBC_A_RXCFG     7'h03
`define SBC_A_RSSITH    7'h04
`define SBC_A_RSSIVAL   7'h05
`define SBC_A_SLPMLO    7'h06
`define SBC_A_SLPMHI    7'h07
`define SBC_A_SLPR      7'h08
`define SBC_A_LVRES     7'h09
`define SBC_A_STATUS    7'h0A
`define SBC_A_SYMDIV    7'h0B
`define SBC_TXCFG_PKT   0
`define SBC_TXCFG_RAMP  1
`define SBC_TXCFG_GAUSS 2
`define SBC_RXCFG_DIR   0
`define SBC_RXCFG_MUTE  3
`define SBC_RXCFG_LATCH 6
`define SBC_RXCFG_IRQPJ 7
`define SBC_MOD_OOK     2'h0
`define SBC_MOD_FSK2    2'h1
`define SBC_MOD_FSK4    2'h2
`define SBC_CMD_SLEEP   8'h01
`define SBC_CMD_STANDBY_STATE    8'h02
`define SBC_CMD_RFS     8'h03
`define SBC_CMD_TFS     8'h04
`define SBC_CMD_RX      8'h05
`define SBC_CMD_TX      8'h06
`define SBC_POW_MIN_DBM (-10)
`define SBC_POW_MAX_DBM 20
`define SBC_RST_TXPOW   5'h0A
`define SBC_RST_TXCFG   8'h06
`define SBC_RST_RXCFG   8'h11
`define SBC_RST_RSSITH  8'h32
`define SBC_RST_SYMDIV  8'h18
`define SBC_RST_TRIM    6'h20
`define SBC_SYS_HZ      100000000
`define SBC_LOW_POWER_OSC_HZ    32000
`define SBC_CAL_TOL_PCT 1
`define SBC_MAX_RUN     4'h4
`define SBC_R_MAX       5'h1A
`endif

//--- sbc_pkg.sv
// Types shared by the baseband control design
package sbc_pkg;
  typedef enum logic [2:0] {
    SBC_SLEEP,
    SBC_STANDBY_STATE,
    SBC_RFS,
    SBC_TFS,
    SBC_RX,
    SBC_TX
  } sbc_state_t;

  typedef struct packed {
    sbc_state_t  state;
    logic [4:0]  txPow;
    logic [7:0]  txCfg;
    logic [7:0]  rxCfg;
    logic [7:0]  rssiTh;
    logic [7:0]  rssiVal;
    logic [10:0] slpM;
    logic        slpEn;
    logic [4:0]  slpR;
    logic        slpSel;
    logic [7:0]  symDiv;
    logic [7:0]  lvResult;
    logic        lvStart;
    logic        lvWait;
    logic [7:0]  rdata;
    logic [7:0]  preCnt;
    logic [1:0]  subCnt;
    logic        subEn;
    logic        symEn;
    logic [1:0]  txSym;
    logic        fifoPop;
    logic [3:0]  shape;
    logic [2:0]  freqDev;
    logic [4:0]  paLevel;
    logic        rxDout;
    logic [2:0]  gpio;
    logic        pktBit;
    logic        pktValid;
    logic        rssiCmp;
    logic        phase_jump_detector;
    logic [3:0]  jumpCnt;
    logic [3:0]  runLen;
    logic        runBad;
    logic        lastBit;
    logic        irqOut;
    logic        slpExt;
    logic [38:0] sleepCnt;
    logic        calPend;
    logic        calRun;
    logic [12:0] calCnt;
    logic        calDone;
    logic [5:0]  trim;
  } sbc_regs_t;
endpackage

//--- sbc_baseband_ctrl.sv
// Baseband control: data paths, PA ramp, shaping, sleep timer, tuning measurement, signal checks
// Summary of operation
// - TX power register accepts -10 to +20 dBm in 1 dB steps, readable.
// - OOK transmit ramps PA level one step per clock at each data edge.
// - Two-level FSK transmit optionally passes symbols through Gaussian shaping, giving GFSK.
// - Direct transmit takes bits from the input pin and sends them unbuffered.
// - Packet transmit takes payload from the FIFO loaded during standby.
// - Four-level FSK transmits only from the FIFO, never from the pin.
// - Direct receive drives demodulated bits to one of three selectable pins.
// - Packet receive hands demodulated bits to the packet handler for the FIFO.
// - Enabled sleep timer counts low-power oscillator ticks and wakes the radio.
// - Sleep interval spans 62.5 us to 8585740.288 s.
// - Low-power oscillator is calibrated at power-up and repeatedly, within 1 percent.
// - Leaving sleep or standby for an active state starts one low-voltage measurement.
// - Signal strength value is either live or latched at packet stages.
// - Signal strength above threshold gives one, otherwise zero.
// - Strength comparison selectable as signal-valid source and low-power receive input.
// - Phase-jump detector runs only in two-level FSK demodulation.
// - Each demodulated bit transition is a jump; two-bit field sets jumps needed.
// - Detector gives one only for valid rate, deviation and SNR above 7 dB.
// - Detector result selectable as signal-valid source or receive-extension condition.
// - Direct receive with mute set suppresses output while detector sees no signal.
//
// Implementation choices: strobed register access and the register addresses.
`include "sbc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sbc_baseband_ctrl
  import sbc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [6:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output var  logic [7:0] regRdata,
  input  wire logic       txDin,
  input  wire logic [1:0] fifoTxSym,
  input  wire logic       fifoTxValid,
  output var  logic       fifoTxPop,
  output var  logic [1:0] txSymbol,
  output var  logic [2:0] freqDev,
  output var  logic [4:0] paLevel,
  input  wire logic       demodBit,
  input  wire logic       demodValid,
  input  wire logic       devOk,
  input  wire logic       snrOk,
  input  wire logic [7:0] rssiLive,
  input  wire logic       pktStage,
  output var  logic       rxDout,
  output var  logic [2:0] doutGpio,
  output var  logic       pktBit,
  output var  logic       pktBitValid,
  output var  logic       rssiCmpOut,
  output var  logic       pjdOut,
  output var  logic       signalValidIrq,
  output var  logic       slpExtend,
  input  wire logic       lposcTick,
  output var  logic [5:0] lposcTrim,
  output var  logic       lvMeasStart,
  input  wire logic       lvDone,
  input  wire logic [7:0] lvData,
  output var  logic [2:0] radioState
);
  localparam int CalNom = `SBC_SYS_HZ / `SBC_LOW_POWER_OSC_HZ;
  localparam int CalTol = CalNom * `SBC_CAL_TOL_PCT / 100;
  localparam logic [12:0] CalHi = 13'(CalNom + CalTol);
  localparam logic [12:0] CalLo = 13'(CalNom - CalTol);

  sbc_regs_t s_q;
  sbc_regs_t s_d;

  // Decoded modes, shared by several paths
  logic [1:0] modSel;
  logic       rxOn;
  logic       txOn;
  logic       fsk2Rx;
  logic       fromFifo;
  logic [3:0] jumpNeed;
  logic [38:0] slpTarget;
  logic [10:0] mEff;
  logic [4:0]  rEff;
  logic        isIdle;
  logic        goActive;
  logic        wakeNow;
  logic        tBit;
  logic [2:0]  shapeSum;

  // Sleep interval is 2*M*2^R ticks of 31.25 us; M and R clamped to their valid span
  always_comb begin
    mEff = (s_q.slpM == 11'h000) ? 11'h001 : s_q.slpM;
    rEff = (s_q.slpR > `SBC_R_MAX) ? `SBC_R_MAX : s_q.slpR;
    slpTarget = {27'h0, mEff, 1'b0} << rEff;
  end

  assign modSel   = s_q.txCfg[4:3];
  assign rxOn     = (s_q.state == SBC_RX);
  assign txOn     = (s_q.state == SBC_TX);
  assign fsk2Rx   = rxOn && (modSel == `SBC_MOD_FSK2);
  assign fromFifo = s_q.txCfg[`SBC_TXCFG_PKT] || (modSel == `SBC_MOD_FSK4);
  assign jumpNeed = {1'b0, s_q.rxCfg[5:4], 1'b0} + 4'h2; // 2,4,6,8 jumps
  assign isIdle   = (s_q.state == SBC_SLEEP) || (s_q.state == SBC_STANDBY_STATE);
  assign tBit     = s_q.txSym[0];
  assign shapeSum = 3'(s_q.shape[0]) + 3'(s_q.shape[1]) + 3'(s_q.shape[2]) + 3'(s_q.shape[3]);

  // Next-state logic for everything the block remembers
  always_comb begin
    s_d = s_q;
    s_d.lvStart  = 1'b0;
    s_d.fifoPop  = 1'b0;
    s_d.pktValid = 1'b0;
    s_d.subEn    = 1'b0;
    s_d.symEn    = 1'b0;
    wakeNow      = 1'b0;

    // Register writes; mode commands outside the code set are ignored
    if (regWr) begin
      unique case (regAddr)
        `SBC_A_MODE: begin
          unique case (regWdata)
            `SBC_CMD_SLEEP: s_d.state = SBC_SLEEP;
            `SBC_CMD_STANDBY_STATE:  s_d.state = SBC_STANDBY_STATE;
            `SBC_CMD_RFS:   s_d.state = SBC_RFS;
            `SBC_CMD_TFS:   s_d.state = SBC_TFS;
            `SBC_CMD_RX:    s_d.state = SBC_RX;
            `SBC_CMD_TX:    s_d.state = SBC_TX;
            default:        s_d.state = s_q.state;
          endcase
        end
        `SBC_A_TXPOW: begin
          // Out-of-span requests clamp to the nearest end
          if ($signed(regWdata) < `SBC_POW_MIN_DBM) begin
            s_d.txPow = 5'h00;
          end else if ($signed(regWdata) > `SBC_POW_MAX_DBM) begin
            s_d.txPow = 5'h1E;
          end else begin
            s_d.txPow = 5'(regWdata + 8'h0A);
          end
        end
        `SBC_A_TXCFG:  s_d.txCfg = regWdata;
        `SBC_A_RXCFG:  s_d.rxCfg = regWdata;
        `SBC_A_RSSITH: s_d.rssiTh = regWdata;
        `SBC_A_SLPMLO: s_d.slpM[7:0] = regWdata;
        `SBC_A_SLPMHI: begin
          s_d.slpM[10:8] = regWdata[2:0];
          s_d.slpEn      = regWdata[7];
        end
        `SBC_A_SLPR: begin
          s_d.slpR   = regWdata[4:0];
          s_d.slpSel = regWdata[7];
        end
        `SBC_A_SYMDIV: s_d.symDiv = regWdata;
        default: s_d.rssiTh = s_q.rssiTh;
      endcase
    end

    // Register reads; unmapped offsets answer zero
    if (regRd) begin
      unique case (regAddr)
        `SBC_A_MODE:    s_d.rdata = {5'h00, s_q.state};
        `SBC_A_TXPOW:   s_d.rdata = {3'h0, s_q.txPow} - 8'h0A;
        `SBC_A_TXCFG:   s_d.rdata = s_q.txCfg;
        `SBC_A_RXCFG:   s_d.rdata = s_q.rxCfg;
        `SBC_A_RSSITH:  s_d.rdata = s_q.rssiTh;
        `SBC_A_RSSIVAL: s_d.rdata = s_q.rssiVal;
        `SBC_A_SLPMLO:  s_d.rdata = s_q.slpM[7:0];
        `SBC_A_SLPMHI:  s_d.rdata = {s_q.slpEn, 4'h0, s_q.slpM[10:8]};
        `SBC_A_SLPR:    s_d.rdata = {s_q.slpSel, 2'h0, s_q.slpR};
        `SBC_A_LVRES:   s_d.rdata = s_q.lvResult;
        `SBC_A_STATUS:  s_d.rdata = {4'h0, s_q.calDone, s_q.lvWait, s_q.phase_jump_detector, s_q.rssiCmp};
        `SBC_A_SYMDIV:  s_d.rdata = s_q.symDiv;
        default:        s_d.rdata = 8'h00;
      endcase
    end

    // Sleep timer wakes into receive; a wake also requests recalibration
    if (s_q.state != SBC_SLEEP || !s_q.slpEn) begin
      s_d.sleepCnt = 39'h0;
    end else if (lposcTick) begin
      if (s_q.sleepCnt + 39'h1 >= slpTarget) begin
        s_d.sleepCnt = 39'h0;
        s_d.state    = SBC_RX;
        s_d.calPend  = 1'b1;
        wakeNow      = 1'b1;
      end else begin
        s_d.sleepCnt = s_q.sleepCnt + 39'h1;
      end
    end

    // Tuning starts one measurement; result kept until the next measurement completes
    goActive = isIdle && (s_d.state != SBC_SLEEP) && (s_d.state != SBC_STANDBY_STATE);
    if (goActive) begin
      s_d.lvStart = 1'b1;
      s_d.lvWait  = 1'b1;
    end else if (s_q.lvWait && lvDone) begin
      s_d.lvWait   = 1'b0;
      s_d.lvResult = lvData;
    end

    // Oscillator calibration: count system clocks over one tick and trim by one step
    if (lposcTick) begin
      if (s_q.calRun) begin
        s_d.calRun  = 1'b0;
        // A wake in the finishing cycle keeps its request: set wins over clear
        s_d.calPend = wakeNow;
        s_d.calDone = 1'b1;
        if (s_q.calCnt > CalHi && s_q.trim != 6'h3F) begin
          s_d.trim = s_q.trim + 6'h01;
        end else if (s_q.calCnt < CalLo && s_q.trim != 6'h00) begin
          s_d.trim = s_q.trim - 6'h01;
        end
      end else if (s_q.calPend) begin
        s_d.calRun = 1'b1;
        s_d.calCnt = 13'h0000;
      end
    end else if (s_q.calRun && s_q.calCnt != 13'h1FFF) begin
      s_d.calCnt = s_q.calCnt + 13'h0001;
    end

    // Symbol timing: four sub-symbol steps per symbol
    if (s_q.preCnt >= s_q.symDiv) begin
      s_d.preCnt = 8'h00;
      s_d.subEn  = 1'b1;
      s_d.subCnt = s_q.subCnt + 2'h1;
      s_d.symEn  = (s_q.subCnt == 2'h3);
    end else begin
      s_d.preCnt = s_q.preCnt + 8'h01;
    end

    // Transmit symbol source; an empty FIFO sends zeros rather than stale data
    if (!txOn) begin
      s_d.txSym = 2'h0;
    end else if (s_q.symEn) begin
      if (fromFifo) begin
        s_d.txSym   = fifoTxValid ? fifoTxSym : 2'h0;
        s_d.fifoPop = fifoTxValid;
      end else begin
        s_d.txSym = {1'b0, txDin};
      end
    end

    // Frequency deviation: Gaussian-like 4-tap sum of oversampled bits in 2FSK
    if (s_q.subEn) begin
      s_d.shape = {s_q.shape[2:0], tBit};
    end
    if (!txOn || modSel == `SBC_MOD_OOK) begin
      s_d.freqDev = 3'h0;
    end else if (modSel == `SBC_MOD_FSK4) begin
      s_d.freqDev = {s_q.txSym, 1'b0};
    end else if (s_q.txCfg[`SBC_TXCFG_GAUSS]) begin
      s_d.freqDev = shapeSum;
    end else begin
      s_d.freqDev = tBit ? 3'h4 : 3'h0;
    end

    // PA level; OOK ramps one step per clock so edges stay soft
    if (!txOn) begin
      s_d.paLevel = 5'h00;
    end else if (modSel != `SBC_MOD_OOK) begin
      s_d.paLevel = s_q.txPow;
    end else if (!s_q.txCfg[`SBC_TXCFG_RAMP]) begin
      s_d.paLevel = tBit ? s_q.txPow : 5'h00;
    end else if (tBit && s_q.paLevel < s_q.txPow) begin
      s_d.paLevel = s_q.paLevel + 5'h01;
    end else if (!tBit && s_q.paLevel != 5'h00) begin
      s_d.paLevel = s_q.paLevel - 5'h01;
    end else if (tBit) begin
      s_d.paLevel = s_q.txPow;
    end

    // Signal strength: live or latched at packet stages, and threshold compare
    if (!s_q.rxCfg[`SBC_RXCFG_LATCH] || pktStage) begin
      s_d.rssiVal = rssiLive;
    end
    s_d.rssiCmp = rssiLive > s_q.rssiTh;

    // Phase-jump detector; cleared on every receive entry and outside 2FSK receive
    if (!fsk2Rx || (s_d.state == SBC_RX && s_q.state != SBC_RX)) begin
      s_d.phase_jump_detector     = 1'b0;
      s_d.jumpCnt = 4'h0;
      s_d.runLen  = 4'h0;
      s_d.runBad  = 1'b0;
      s_d.lastBit = demodBit;
    end else if (demodValid) begin
      s_d.lastBit = demodBit;
      if (demodBit != s_q.lastBit) begin
        // Long runs between jumps mean the bit rate does not match
        if (s_q.jumpCnt + 4'h1 >= jumpNeed) begin
          s_d.phase_jump_detector     = snrOk && devOk && !s_q.runBad && (s_q.runLen <= `SBC_MAX_RUN);
          s_d.jumpCnt = 4'h0;
          s_d.runBad  = 1'b0;
        end else begin
          s_d.jumpCnt = s_q.jumpCnt + 4'h1;
          s_d.runBad  = s_q.runBad || (s_q.runLen > `SBC_MAX_RUN);
        end
        s_d.runLen = 4'h0;
      end else if (s_q.runLen != 4'hF) begin
        s_d.runLen = s_q.runLen + 4'h1;
      end
    end

    // Source selection for the signal-valid line and receive extension
    s_d.irqOut = s_q.rxCfg[`SBC_RXCFG_IRQPJ] ? s_q.phase_jump_detector : s_q.rssiCmp;
    s_d.slpExt = s_q.slpSel ? s_q.phase_jump_detector : s_q.rssiCmp;

    // Receive data paths; outside 2FSK the detector is held at zero, so mute silences the output entirely there
    if (!rxOn || !s_q.rxCfg[`SBC_RXCFG_DIR]) begin
      s_d.rxDout = 1'b0;
    end else if (s_q.rxCfg[`SBC_RXCFG_MUTE] && !s_q.phase_jump_detector) begin
      s_d.rxDout = 1'b0;
    end else if (demodValid) begin
      s_d.rxDout = demodBit;
    end
    unique case (s_q.rxCfg[2:1])
      2'h1:    s_d.gpio = {1'b0, s_d.rxDout, 1'b0};
      2'h2:    s_d.gpio = {s_d.rxDout, 2'h0};
      default: s_d.gpio = {2'h0, s_d.rxDout};
    endcase
    if (rxOn && !s_q.rxCfg[`SBC_RXCFG_DIR] && demodValid) begin
      s_d.pktBit   = demodBit;
      s_d.pktValid = 1'b1;
    end
  end

  // State register with synchronous reset; oscillator calibration armed from power-up
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q         <= '0;
      s_q.state   <= SBC_SLEEP;
      s_q.txPow   <= `SBC_RST_TXPOW;
      s_q.txCfg   <= `SBC_RST_TXCFG;
      s_q.rxCfg   <= `SBC_RST_RXCFG;
      s_q.rssiTh  <= `SBC_RST_RSSITH;
      s_q.symDiv  <= `SBC_RST_SYMDIV;
      s_q.slpM    <= 11'h001;
      s_q.trim    <= `SBC_RST_TRIM;
      s_q.calPend <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata       = s_q.rdata;
  assign fifoTxPop      = s_q.fifoPop;
  assign txSymbol       = s_q.txSym;
  assign freqDev        = s_q.freqDev;
  assign paLevel        = s_q.paLevel;
  assign rxDout         = s_q.rxDout;
  assign doutGpio       = s_q.gpio;
  assign pktBit         = s_q.pktBit;
  assign pktBitValid    = s_q.pktValid;
  assign rssiCmpOut     = s_q.rssiCmp;
  assign pjdOut         = s_q.phase_jump_detector;
  assign signalValidIrq = s_q.irqOut;
  assign slpExtend      = s_q.slpExt;
  assign lposcTrim      = s_q.trim;
  assign lvMeasStart    = s_q.lvStart;
  assign radioState     = s_q.state;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_pow_range;
    s_q.txPow <= 5'h1E;
  endproperty
  a_pow_range: assert property (p_pow_range) else $error("power code out of span");

  property p_ramp;
    (txOn && modSel == `SBC_MOD_OOK && s_q.txCfg[`SBC_TXCFG_RAMP]) ##1 txOn
      |-> (paLevel == $past(paLevel) || paLevel == $past(paLevel) + 5'h01
           || paLevel == $past(paLevel) - 5'h01);
  endproperty
  a_ramp: assert property (p_ramp) else $error("PA level jumped");

  property p_direct_tx;
    (txOn && !fromFifo && s_q.symEn) ##1 txOn |-> txSymbol == {1'b0, $past(txDin)};
  endproperty
  a_direct_tx: assert property (p_direct_tx) else $error("direct bit not sent");

  property p_fsk4_fifo;
    (txOn && modSel == `SBC_MOD_FSK4 && s_q.symEn && fifoTxValid) |=> fifoTxPop;
  endproperty
  a_fsk4_fifo: assert property (p_fsk4_fifo) else $error("4FSK did not pop FIFO");

  property p_pkt_rx;
    (rxOn && !s_q.rxCfg[`SBC_RXCFG_DIR] && demodValid) |=> pktBitValid && pktBit == $past(demodBit);
  endproperty
  a_pkt_rx: assert property (p_pkt_rx) else $error("packet bit lost");

  property p_lv_tune;
    (isIdle && s_d.state != SBC_SLEEP && s_d.state != SBC_STANDBY_STATE) |=> lvMeasStart ##1 !lvMeasStart;
  endproperty
  a_lv_tune: assert property (p_lv_tune) else $error("no single measurement on tuning");

  property p_rssi_cmp;
    (rssiLive > s_q.rssiTh) ##1 (s_q.rxCfg[`SBC_RXCFG_IRQPJ] == 1'b0) |=> signalValidIrq;
  endproperty
  a_rssi_cmp: assert property (p_rssi_cmp) else $error("strength compare not routed");

  property p_pjd_off;
    !fsk2Rx |=> !pjdOut;
  endproperty
  a_pjd_off: assert property (p_pjd_off) else $error("detector active outside 2FSK rx");

  property p_rx_clear;
    (s_d.state == SBC_RX && s_q.state != SBC_RX) |=> s_q.jumpCnt == 4'h0 && !pjdOut;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("detector not restarted");

  property p_mute;
    (rxOn && s_q.rxCfg[`SBC_RXCFG_DIR] && s_q.rxCfg[`SBC_RXCFG_MUTE] && !pjdOut) |=> !rxDout;
  endproperty
  a_mute: assert property (p_mute) else $error("muted output not suppressed");

  c_wake: cover property ((s_q.state == SBC_SLEEP) ##1 (s_q.state == SBC_RX));
  c_pjd_hit: cover property (!pjdOut ##1 pjdOut);
  c_ook_ramp: cover property (txOn && modSel == `SBC_MOD_OOK && paLevel == s_q.txPow);
endmodule
`default_nettype wire

//--- sbc_far_model.sv
// Far-side model: host transmit FIFO and a demodulated preamble source
`timescale 1ns/10ps
`default_nettype none
module sbc_far_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       pushEn,
  input  wire logic [1:0] pushSym,
  input  wire logic       streamOn,
  input  wire logic       fifoTxPop,
  output var  logic [1:0] fifoTxSym,
  output var  logic       fifoTxValid,
  output var  logic       demodBit,
  output var  logic       demodValid
);
  logic [1:0] fifoQ [$];
  logic [1:0] divCnt;

  // Host fills the FIFO while the radio idles; an empty head shows a moving pattern, not stale data
  always @(posedge clk_sys) begin
    if (!nrst) begin
      fifoQ.delete();
      fifoTxValid <= 1'b0;
      fifoTxSym   <= 2'h0;
    end else begin
      if (fifoTxPop && fifoQ.size() > 0) begin
        void'(fifoQ.pop_front());
      end
      if (pushEn) begin
        fifoQ.push_back(pushSym);
      end
      fifoTxValid <= (fifoQ.size() > 0);
      fifoTxSym   <= (fifoQ.size() > 0) ? fifoQ[0] : ~fifoTxSym;
    end
  end

  // Preamble source: a new bit every four clocks, each one a jump; idle line toggles every clock
  always @(posedge clk_sys) begin
    if (!nrst) begin
      divCnt     <= 2'h0;
      demodBit   <= 1'b0;
      demodValid <= 1'b0;
    end else begin
      divCnt     <= divCnt + 2'h1;
      demodValid <= streamOn && (divCnt == 2'h3);
      if (!streamOn || divCnt == 2'h3) begin
        demodBit <= ~demodBit;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the baseband control block
`include "sbc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk_sys, nrst, regWr, regRd, txDin, fifoTxValid, fifoTxPop, demodBit;
  logic       demodValid, devOk, snrOk, pktStage, rxDout, pktBit, pktBitValid, rssiCmpOut;
  logic       pjdOut, signalValidIrq, slpExtend, lposcTick, lvMeasStart, lvDone;
  logic       pushEn, streamOn;
  logic [1:0] fifoTxSym, txSymbol, pushSym;
  logic [2:0] freqDev, doutGpio, radioState;
  logic [4:0] paLevel;
  logic [5:0] lposcTrim;
  logic [6:0] regAddr;
  logic [7:0] regWdata, regRdata, rssiLive, lvData, rd;
  int         n_fail, total_checks, lvPulses, pktBits;

  sbc_baseband_ctrl dut (.clk_sys, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .txDin, .fifoTxSym, .fifoTxValid, .fifoTxPop, .txSymbol, .freqDev, .paLevel, .demodBit,
    .demodValid, .devOk, .snrOk, .rssiLive, .pktStage, .rxDout, .doutGpio, .pktBit,
    .pktBitValid, .rssiCmpOut, .pjdOut, .signalValidIrq, .slpExtend, .lposcTick, .lposcTrim,
    .lvMeasStart, .lvDone, .lvData, .radioState);
  sbc_far_model far (.clk_sys, .nrst, .pushEn, .pushSym, .streamOn, .fifoTxPop, .fifoTxSym,
    .fifoTxValid, .demodBit, .demodValid);

  // Clock and pulse counters
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (lvMeasStart === 1'b1) lvPulses++;
    if (pktBitValid === 1'b1) pktBits++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Bus cycles: one strobe cycle, read data taken in the cycle after
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask

  task automatic rdr(input logic [6:0] a);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    @(negedge clk_sys);
    rd = regRdata;
  endtask

  task automatic tick();
    @(posedge clk_sys);
    lposcTick <= 1'b1;
    @(posedge clk_sys);
    lposcTick <= 1'b0;
  endtask

  task automatic t_regs();
    logic [6:0] ra [6] = '{`SBC_A_TXCFG, `SBC_A_RXCFG, `SBC_A_RSSITH, `SBC_A_SYMDIV, 7'h7F, `SBC_A_MODE};
    logic [7:0] re [6] = '{8'h06, 8'h11, 8'h32, 8'h18, 8'h00, 8'h00};
    logic [7:0] pw [5] = '{8'hF6, 8'h14, 8'h19, 8'hEC, 8'h05};
    logic [7:0] pe [5] = '{8'hF6, 8'h14, 8'h14, 8'hF6, 8'h05};
    chk(8'(lposcTrim), 8'h20, "trim reset");
    foreach (ra[i]) begin
      rdr(ra[i]);
      chk(rd, re[i], "reset value");
    end
    foreach (pw[i]) begin
      wr(`SBC_A_TXPOW, pw[i]);
      rdr(`SBC_A_TXPOW);
      chk(rd, pe[i], "power setting");
    end
    wr(`SBC_A_TXPOW, 8'h00);
    rssiLive <= 8'h33;
    cyc(3);
    chk(8'(rssiCmpOut), 8'h01, "strength above");
    chk(8'(signalValidIrq), 8'h01, "irq from strength");
    chk(8'(slpExtend), 8'h01, "extend from strength");
    rdr(`SBC_A_RSSIVAL);
    chk(rd, 8'h33, "live strength value");
    rssiLive <= 8'h32;
    cyc(3);
    chk(8'(rssiCmpOut), 8'h00, "strength equal");
  endtask

  // Four-level FSK ignores the pin; entering transmit starts one measurement
  task automatic t_fsk4();
    int n;
    wr(`SBC_A_MODE, `SBC_CMD_STANDBY_STATE);
    wr(`SBC_A_SYMDIV, 8'h00);
    wr(`SBC_A_TXCFG, 8'h10);
    @(posedge clk_sys);
    pushEn  <= 1'b1;
    pushSym <= 2'h3;
    @(posedge clk_sys);
    pushEn  <= 1'b0;
    txDin   <= 1'b1;
    lvPulses = 0;
    wr(`SBC_A_MODE, `SBC_CMD_TX);
    for (n = 0; n < 50 && txSymbol !== 2'h3; n++) @(posedge clk_sys);
    chk(8'(txSymbol), 8'h03, "fifo symbol");
    cyc(12);
    chk(8'(txSymbol), 8'h00, "pin ignored");
    chk(8'(lvPulses), 8'h01, "one measurement");
    lvData <= 8'h5A;
    lvDone <= 1'b1;
    @(posedge clk_sys);
    lvDone <= 1'b0;
    rdr(`SBC_A_LVRES);
    chk(rd, 8'h5A, "measurement result");
  endtask

  // Direct two-level FSK, shaped and plain
  task automatic t_fsk2();
    int   n;
    logic mid;
    mid = 1'b0;
    wr(`SBC_A_MODE, `SBC_CMD_STANDBY_STATE);
    txDin <= 1'b0;
    wr(`SBC_A_TXCFG, 8'h0C);
    wr(`SBC_A_MODE, `SBC_CMD_TX);
    cyc(30);
    txDin <= 1'b1;
    for (n = 0; n < 60 && freqDev !== 3'h4; n++) begin
      @(negedge clk_sys);
      if (freqDev inside {3'h1, 3'h2, 3'h3}) mid = 1'b1;
    end
    chk(8'(mid), 8'h01, "shaped steps");
    wr(`SBC_A_TXCFG, 8'h08);
    txDin <= 1'b0;
    cyc(10);
    chk(8'(txSymbol), 8'h00, "pin low");
    txDin <= 1'b1;
    for (n = 0; n < 20 && txSymbol !== 2'h1; n++) @(negedge clk_sys);
    chk(8'(txSymbol), 8'h01, "pin high");
    @(negedge clk_sys);
    chk(8'(freqDev), 8'h04, "plain deviation");
  endtask

  logic pw_dir [2] = '{1'b1, 1'b0};

  // On-off keying: PA code never jumps more than one step per clock
  task automatic t_ook();
    logic [4:0] prev;
    int         steep;
    steep = 0;
    wr(`SBC_A_TXCFG, 8'h02);
    foreach (pw_dir[i]) begin
      txDin <= pw_dir[i];
      @(negedge clk_sys);
      prev = paLevel;
      repeat (30) begin
        @(negedge clk_sys);
        if (paLevel > prev + 1 || prev > paLevel + 1) steep++;
        prev = paLevel;
      end
      chk(8'(paLevel), pw_dir[i] ? 8'h0A : 8'h00, "ramp end");
    end
    chk(8'(steep), 8'h00, "ramp slope");
  endtask

  // Detector: count, verdict, mute, entry clear, mode gating
  task automatic t_pjd();
    int n;
    int ones;
    ones = 0;
    wr(`SBC_A_MODE, `SBC_CMD_STANDBY_STATE);
    wr(`SBC_A_TXCFG, 8'h08);
    wr(`SBC_A_RXCFG, 8'h93);
    devOk    <= 1'b1;
    snrOk    <= 1'b1;
    streamOn <= 1'b1;
    wr(`SBC_A_MODE, `SBC_CMD_RX);
    for (n = 0; n < 200 && pjdOut !== 1'b1; n++) @(negedge clk_sys);
    chk(8'(pjdOut), 8'h01, "verdict good");
    chk(8'(n >= 12), 8'h01, "four jumps needed");
    cyc(2);
    @(negedge clk_sys);
    chk(8'(signalValidIrq), 8'h01, "irq from detector");
    chk(8'(doutGpio), 8'({1'b0, rxDout, 1'b0}), "pin routing");
    wr(`SBC_A_MODE, `SBC_CMD_STANDBY_STATE);
    snrOk <= 1'b0;
    wr(`SBC_A_RXCFG, 8'h1B);
    wr(`SBC_A_MODE, `SBC_CMD_RX);
    repeat (60) begin
      @(negedge clk_sys);
      if (rxDout !== 1'b0) ones++;
    end
    chk(8'(pjdOut), 8'h00, "verdict noisy");
    chk(8'(ones), 8'h00, "muted output");
    wr(`SBC_A_MODE, `SBC_CMD_STANDBY_STATE);
    snrOk <= 1'b1;
    wr(`SBC_A_TXCFG, 8'h00);
    wr(`SBC_A_RXCFG, 8'h10);
    pktBits = 0;
    wr(`SBC_A_MODE, `SBC_CMD_RX);
    cyc(60);
    chk(8'(pjdOut), 8'h00, "on-off keying");
    chk(8'(pktBits > 0), 8'h01, "packet path");
    streamOn <= 1'b0;
  endtask

  // Sleep timer wake after two ticks, then a slow period raises the trim
  task automatic t_sleep();
    logic [5:0] t0;
    wr(`SBC_A_SLPMLO, 8'h00);
    wr(`SBC_A_SLPMHI, 8'h80);
    wr(`SBC_A_SLPR, 8'h00);
    wr(`SBC_A_MODE, `SBC_CMD_SLEEP);
    lvPulses = 0;
    tick();
    cyc(4);
    chk(8'(radioState), 8'h00, "still asleep");
    tick();
    cyc(4);
    chk(8'(radioState), 8'h04, "woke to receive");
    chk(8'(lvPulses), 8'h01, "wake measurement");
    t0 = lposcTrim;
    tick();
    cyc(3200);
    tick();
    cyc(4);
    chk(8'(lposcTrim), 8'(t0 + 6'h01), "slow oscillator trim");
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence: all inputs defined at time zero, reset held six clocks
  initial begin
    {clk_sys, nrst, regWr, regRd, txDin, devOk, snrOk, pktStage, lposcTick, lvDone} = '0;
    {pushEn, streamOn, pushSym, regAddr, regWdata, rssiLive, lvData} = '0;
    cyc(6);
    nrst <= 1'b1;
    t_regs();
    $display("test regs done");
    t_fsk4();
    $display("test fsk4 done");
    t_fsk2();
    $display("test fsk2 done");
    t_ook();
    $display("test ook done");
    t_pjd();
    $display("test detector done");
    t_sleep();
    $display("test sleep done");
    complete_run();
  end

  // Watchdog: the whole sequence needs about 3600 clocks
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
`default_nettype wire
